// >>> ttsr_pkg.sv
`default_nettype none
package ttsr_pkg;
  localparam int unsigned TTSR_ADDR_W = 12;
  localparam int unsigned TTSR_DATA_W = 32;
  localparam int unsigned TTSR_IDX_W = 10;
  localparam int unsigned TTSR_SLOTS = 32;
  localparam int unsigned TTSR_SLOT_W = 5;
  // register indexes; byte address is four times the index
  localparam logic [TTSR_IDX_W-1:0] TTSR_IDX_PART = 10'h1fe;
  localparam logic [TTSR_IDX_W-1:0] TTSR_IDX_REV = 10'h1ff;
  localparam logic [TTSR_IDX_W-1:0] TTSR_IDX_SLOT_BASE = 10'h300;
  localparam logic [TTSR_IDX_W-1:0] TTSR_IDX_SLOT_LAST = 10'h31f;
  // field layout of a timeslot control word
  localparam int unsigned TTSR_SEL_HI = 7;
  localparam int unsigned TTSR_SEL_LO = 6;
  localparam int unsigned TTSR_RSV_HI = 5;
  localparam int unsigned TTSR_RSV_LO = 4;
  localparam int unsigned TTSR_ID_HI = 7;
  localparam logic [1:0] TTSR_SEL_RST = 2'h2;
  localparam logic [1:0] TTSR_SRC_RST = 2'h0;
  localparam logic [TTSR_DATA_W-1:0] TTSR_RDATA_ZERO = 32'h0;
  localparam logic [1:0] TTSR_ALIGN_OK = 2'h0;
  localparam logic [TTSR_SLOT_W-1:0] TTSR_SLOT_FIRST = 5'h00;
  localparam logic [TTSR_SLOT_W-1:0] TTSR_SLOT_STEP = 5'h01;

  typedef enum logic [1:0] {
    TTSR_SEL_HDLC1 = 2'b00,
    TTSR_SEL_HDLC2 = 2'b01,
    TTSR_SEL_FOLLOW = 2'b10,
    TTSR_SEL_HDLC3 = 2'b11
  } ttsr_sel_e;

  localparam logic [2:0] TTSR_HOT_NONE = 3'h0;
  localparam logic [2:0] TTSR_HOT_HDLC1 = 3'h1;
  localparam logic [2:0] TTSR_HOT_HDLC2 = 3'h2;
  localparam logic [2:0] TTSR_HOT_HDLC3 = 3'h4;

  function automatic logic [TTSR_IDX_W-1:0] ttsr_index(input logic [TTSR_ADDR_W-1:0] addr);
    ttsr_index = addr[TTSR_ADDR_W-1:2];
  endfunction

  function automatic logic ttsr_aligned(input logic [TTSR_ADDR_W-1:0] addr);
    ttsr_aligned = (addr[1:0] == TTSR_ALIGN_OK);
  endfunction

  function automatic logic ttsr_is_slot(input logic [TTSR_IDX_W-1:0] idx);
    ttsr_is_slot = (idx >= TTSR_IDX_SLOT_BASE) && (idx <= TTSR_IDX_SLOT_LAST);
  endfunction

  function automatic logic [TTSR_SLOT_W-1:0] ttsr_slot_of(input logic [TTSR_IDX_W-1:0] idx);
    logic [TTSR_IDX_W-1:0] diff;
    diff = idx - TTSR_IDX_SLOT_BASE;
    ttsr_slot_of = diff[TTSR_SLOT_W-1:0];
  endfunction
endpackage
`default_nettype wire

// >>> ttsr_regs.sv
// Behaviour
// RULE1: part identifier register is read-only, fixed code, writes never change it.
// RULE2: revision register is read-only and returns a fixed first-revision code.
// RULE3: software must not rely on one revision code; later silicon may differ.
// RULE4: thirty-two timeslot control registers at consecutive addresses, timeslots 0 to 31.
// RULE5: lowest control register is timeslot 0, each higher one the next.
// RULE6: select 00 steers to controller 1, 01 to 2, 11 to 3.
// RULE7: select 10 makes the timeslot follow the two-bit source setting.
// RULE8: any controller may take timeslots; only controller 1 gets link bits.
// RULE9: bits 5 and 4 of each control register are reserved, no function.
// RULE10: select sits in bits 7:6, read/write, effective next timeslot occurrence.
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
module ttsr_regs
  import ttsr_pkg::*;
#(
  // value is arbitrary
  parameter logic [7:0] PART_ID = 8'ha7,
  // value is arbitrary
  parameter logic [7:0] REV_ID = 8'h5c
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [TTSR_ADDR_W-1:0] paddr_i,
  input wire logic [TTSR_DATA_W-1:0] pwdata_i,
  output logic [TTSR_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic frame_start_i,
  input wire logic slot_tick_i,
  input wire logic [1:0] timeslot_source_setting_i,
  input wire logic dl_window_i,
  output logic [TTSR_SLOT_W-1:0] cur_slot_o,
  output logic slot_start_o,
  output logic [2:0] hdlc_route_o,
  output logic source_follow_o,
  output logic [1:0] source_setting_o,
  output logic dl_hdlc1_o
);
  logic [TTSR_DATA_W-1:0] prdata_q;
  logic [TTSR_DATA_W-1:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [1:0] sel_q [TTSR_SLOTS];
  logic [1:0] sel_d [TTSR_SLOTS];
  logic [TTSR_IDX_W-1:0] acc_idx;
  logic [TTSR_SLOT_W-1:0] acc_slot;
  logic acc_aligned;
  logic acc_is_slot;
  logic setup_phase;
  logic wr_commit;
  logic [TTSR_SLOT_W-1:0] slot_now;
  logic slot_start_now;
  logic [1:0] cur_sel;

  assign acc_idx = ttsr_index(paddr_i);
  assign acc_aligned = ttsr_aligned(paddr_i);
  assign acc_is_slot = ttsr_is_slot(acc_idx);
  assign acc_slot = ttsr_slot_of(acc_idx);
  assign setup_phase = psel_i && !penable_i;
  // commit only at the edge where the master sees pready, never in setup
  assign wr_commit = psel_i && penable_i && pwrite_i && pready_q && !pslverr_q;

  // read data is captured in setup; the sole master cannot write in between
  always_comb
  begin
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup_phase)
    begin
      pready_d = 1'b1;
      prdata_d = TTSR_RDATA_ZERO;
      if (!acc_aligned)
      begin
        pslverr_d = 1'b1;
      end
      else if (acc_idx == TTSR_IDX_PART)
      begin
        // RULE1: fixed part code
        if (pwrite_i)
        begin
          pslverr_d = 1'b1;
        end
        else
        begin
          prdata_d[TTSR_ID_HI:0] = PART_ID;
        end
      end
      else if (acc_idx == TTSR_IDX_REV)
      begin
        // RULE2: fixed revision code
        if (pwrite_i)
        begin
          pslverr_d = 1'b1;
        end
        else
        begin
          prdata_d[TTSR_ID_HI:0] = REV_ID;
        end
      end
      else if (acc_is_slot)
      begin
        // RULE9: reserved bits read zero
        if (!pwrite_i)
        begin
          prdata_d[TTSR_SEL_HI:TTSR_SEL_LO] = sel_q[acc_slot];
        end
      end
      else
      begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      prdata_q <= TTSR_RDATA_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // RULE4: one select per timeslot
  always_comb
  begin
    sel_d = sel_q;
    // RULE10: select field write
    if (wr_commit && acc_aligned && acc_is_slot)
    begin
      // RULE5: address order is slot order
      sel_d[acc_slot] = pwdata_i[TTSR_SEL_HI:TTSR_SEL_LO];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < TTSR_SLOTS; i++)
      begin
        sel_q[i] <= TTSR_SEL_RST;
      end
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  ttsr_slot_cnt u_slot_cnt (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .frame_start_i(frame_start_i),
    .slot_tick_i(slot_tick_i),
    .slot_o(slot_now),
    .slot_start_o(slot_start_now)
  );

  // RULE10: sampled at slot start
  assign cur_sel = sel_q[slot_now];

  ttsr_route u_route (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .slot_start_i(slot_start_now),
    .select_i(cur_sel),
    .source_setting_i(timeslot_source_setting_i),
    .dl_window_i(dl_window_i),
    .hdlc_route_o(hdlc_route_o),
    .source_follow_o(source_follow_o),
    .source_setting_o(source_setting_o),
    .dl_hdlc1_o(dl_hdlc1_o)
  );

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign cur_slot_o = slot_now;
  assign slot_start_o = slot_start_now;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_setup_rd;
    psel_i && !penable_i && !pwrite_i && acc_aligned;
  endsequence

  sequence s_access;
    psel_i && penable_i && pready_q;
  endsequence

  sequence s_setup_wr_slot;
    psel_i && !penable_i && pwrite_i && acc_aligned && acc_is_slot;
  endsequence

  AST_PART_ID_READ: assert property ( // RULE1
    s_setup_rd ##0 (acc_idx == TTSR_IDX_PART) |=> s_access ##0 (prdata_q == {24'h0, PART_ID}))
    else $error("part identifier read returned wrong value");

  AST_ID_WRITE_REFUSED: assert property ( // RULE1
    psel_i && !penable_i && pwrite_i && acc_aligned &&
    (acc_idx == TTSR_IDX_PART || acc_idx == TTSR_IDX_REV) |=> pslverr_q && pready_q)
    else $error("write to identifier not refused");

  AST_REV_READ: assert property ( // RULE2
    s_setup_rd ##0 (acc_idx == TTSR_IDX_REV) |=> (prdata_q == {24'h0, REV_ID}))
    else $error("revision read returned wrong value");

  AST_SLOT_WRITE: assert property ( // RULE4
    s_setup_wr_slot ##1 (s_access ##0 penable_i) |=>
    (sel_q[$past(acc_slot)] == $past(pwdata_i[TTSR_SEL_HI:TTSR_SEL_LO])))
    else $error("timeslot select not stored");

  AST_SLOT_READ_MAP: assert property ( // RULE5
    s_setup_rd ##0 acc_is_slot |=>
    (prdata_q[TTSR_SEL_HI:TTSR_SEL_LO] == sel_q[$past(acc_slot)]))
    else $error("timeslot read maps to wrong slot");

  AST_RESERVED_ZERO: assert property ( // RULE9
    s_setup_rd ##0 acc_is_slot |=>
    (prdata_q[TTSR_RSV_HI:0] == 6'h00) && (prdata_q[TTSR_DATA_W-1:TTSR_SEL_HI+1] == 24'h0))
    else $error("reserved bits not zero");

  AST_PREADY_PULSE: assert property ( // RULE4
    psel_i && !penable_i |=> pready_q ##1 !pready_q)
    else $error("pready not a one-cycle answer");

  AST_ROUTE_HDLC: assert property ( // RULE6
    slot_start_now && (cur_sel != TTSR_SEL_FOLLOW) |=>
    (hdlc_route_o == (($past(cur_sel) == TTSR_SEL_HDLC1) ? TTSR_HOT_HDLC1 :
                      ($past(cur_sel) == TTSR_SEL_HDLC2) ? TTSR_HOT_HDLC2 : TTSR_HOT_HDLC3))
    && !source_follow_o)
    else $error("timeslot steered to wrong controller");

  AST_ROUTE_FOLLOW: assert property ( // RULE7
    slot_start_now && (cur_sel == TTSR_SEL_FOLLOW) |=>
    source_follow_o && (hdlc_route_o == TTSR_HOT_NONE) &&
    (source_setting_o == $past(timeslot_source_setting_i)))
    else $error("follow select did not take source setting");

  AST_DL_ONLY_HDLC1: assert property ( // RULE8
    dl_window_i |=> dl_hdlc1_o)
    else $error("link bits not given to controller 1");

  AST_ROUTE_HELD: assert property ( // RULE10
    !slot_start_now |=> $stable(hdlc_route_o) && $stable(source_follow_o))
    else $error("routing changed outside a slot start");

  sequence s_tick_only;
    slot_tick_i && !frame_start_i;
  endsequence

  AST_FRAME_TO_SLOT0: assert property ( // RULE5
    frame_start_i |=> slot_start_now && (slot_now == TTSR_SLOT_FIRST))
    else $error("frame start did not select timeslot 0");

  AST_TICK_NEXT_SLOT: assert property ( // RULE5
    s_tick_only |=> slot_start_now && (slot_now == $past(slot_now) + TTSR_SLOT_STEP))
    else $error("tick did not advance to the next timeslot");

  AST_SLOT_IDLE: assert property ( // RULE5
    !frame_start_i && !slot_tick_i |=> !slot_start_now && $stable(slot_now))
    else $error("timeslot moved without a tick");

  AST_SLOT_READ_OK: assert property ( // RULE4
    s_setup_rd ##0 acc_is_slot |=> pready_q && !pslverr_q)
    else $error("timeslot read refused");

  AST_UNMAPPED_REFUSED: assert property ( // RULE4
    psel_i && !penable_i && acc_aligned && !acc_is_slot &&
    (acc_idx != TTSR_IDX_PART) && (acc_idx != TTSR_IDX_REV) |=> pready_q && pslverr_q)
    else $error("unmapped access not refused");

  AST_IDLE_QUIET: assert property ( // RULE4
    !setup_phase |=> !pready_q && !pslverr_q)
    else $error("answer without a setup cycle");

  AST_ONE_CONTROLLER: assert property ( // RULE8
    $onehot0(hdlc_route_o))
    else $error("timeslot steered to more than one controller");

  AST_FOLLOW_NO_HDLC: assert property ( // RULE7
    source_follow_o |-> (hdlc_route_o == TTSR_HOT_NONE))
    else $error("following timeslot also steered to a controller");

  AST_SRC_IDLE_ZERO: assert property ( // RULE7
    !source_follow_o |-> (source_setting_o == TTSR_SRC_RST))
    else $error("source setting shown without follow select");

  AST_DL_OUTSIDE_WINDOW: assert property ( // RULE8
    !dl_window_i |=> !dl_hdlc1_o)
    else $error("link bits flagged outside the link window");
endmodule // ttsr_regs
`default_nettype wire

// >>> ttsr_route.sv
`default_nettype none
module ttsr_route
  import ttsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic slot_start_i,
  input wire logic [1:0] select_i,
  input wire logic [1:0] source_setting_i,
  input wire logic dl_window_i,
  output logic [2:0] hdlc_route_o,
  output logic source_follow_o,
  output logic [1:0] source_setting_o,
  output logic dl_hdlc1_o
);
  logic [2:0] route_q;
  logic [2:0] route_d;
  logic follow_q;
  logic follow_d;
  logic [1:0] src_q;
  logic [1:0] src_d;
  logic dl_q;
  logic dl_d;

  always_comb
  begin
    route_d = route_q;
    follow_d = follow_q;
    src_d = src_q;
    // RULE8: link bits to controller 1
    dl_d = dl_window_i;
    if (slot_start_i)
    begin
      route_d = TTSR_HOT_NONE;
      follow_d = 1'b0;
      src_d = TTSR_SRC_RST;
      // RULE6: select decode steering
      case (ttsr_sel_e'(select_i))
        TTSR_SEL_HDLC1: route_d = TTSR_HOT_HDLC1;
        TTSR_SEL_HDLC2: route_d = TTSR_HOT_HDLC2;
        TTSR_SEL_HDLC3: route_d = TTSR_HOT_HDLC3;
        // RULE7: follow source setting
        TTSR_SEL_FOLLOW:
        begin
          follow_d = 1'b1;
          src_d = source_setting_i;
        end
        default: route_d = TTSR_HOT_NONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      route_q <= TTSR_HOT_NONE;
      follow_q <= 1'b0;
      src_q <= TTSR_SRC_RST;
      dl_q <= 1'b0;
    end
    else
    begin
      route_q <= route_d;
      follow_q <= follow_d;
      src_q <= src_d;
      dl_q <= dl_d;
    end
  end

  assign hdlc_route_o = route_q;
  assign source_follow_o = follow_q;
  assign source_setting_o = src_q;
  assign dl_hdlc1_o = dl_q;
endmodule // ttsr_route
`default_nettype wire

// >>> ttsr_slot_cnt.sv
`default_nettype none
module ttsr_slot_cnt
  import ttsr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic frame_start_i,
  input wire logic slot_tick_i,
  output logic [TTSR_SLOT_W-1:0] slot_o,
  output logic slot_start_o
);
  logic [TTSR_SLOT_W-1:0] slot_q;
  logic [TTSR_SLOT_W-1:0] slot_d;
  logic start_q;
  logic start_d;

  // frame start wins over a tick so a late tick cannot skew the count
  always_comb
  begin
    slot_d = slot_q;
    start_d = 1'b0;
    if (frame_start_i)
    begin
      slot_d = TTSR_SLOT_FIRST;
      start_d = 1'b1;
    end
    else if (slot_tick_i)
    begin
      slot_d = slot_q + TTSR_SLOT_STEP;
      start_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      slot_q <= TTSR_SLOT_FIRST;
      start_q <= 1'b0;
    end
    else
    begin
      slot_q <= slot_d;
      start_q <= start_d;
    end
  end

  assign slot_o = slot_q;
  assign slot_start_o = start_q;
endmodule // ttsr_slot_cnt
`default_nettype wire

// >>> tx_timeslot_hdlc_select_regs_test.sv
`default_nettype none
module tx_timeslot_hdlc_select_regs_test
  import ttsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // identifier values are arbitrary
  localparam logic [7:0] PID = 8'h3d;
  localparam logic [7:0] RID = 8'h91;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [TTSR_ADDR_W-1:0] paddr = '0;
  logic [TTSR_DATA_W-1:0] pwdata = '0, prdata;
  logic pready, pslverr, fs = 1'b0, tick = 1'b0, dlw = 1'b0, slot_start, follow, dl1;
  logic [1:0] src = 2'h0, src_o;
  logic [TTSR_SLOT_W-1:0] cur_slot;
  logic [2:0] route;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;

  ttsr_regs #(.PART_ID(PID), .REV_ID(RID)) u_dut (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .frame_start_i(fs), .slot_tick_i(tick), .timeslot_source_setting_i(src),
    .dl_window_i(dlw), .cur_slot_o(cur_slot), .slot_start_o(slot_start),
    .hdlc_route_o(route), .source_follow_o(follow), .source_setting_o(src_o),
    .dl_hdlc1_o(dl1));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk_i);
    pen <= 1'b1;
    @(posedge sys_clk_i);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge sys_clk_i);
    end
    if (n == 20) chk(32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  function automatic logic [11:0] slot_addr(input int k);
    slot_addr = {TTSR_IDX_SLOT_BASE + 10'(k), 2'b00};
  endfunction

  task automatic t_ident();
    apb(1'b0, {TTSR_IDX_PART, 2'b00}, 32'h0, rd, er); chk(rd, {24'h0, PID});
    chk({31'h0, er}, 32'h0);
    @(posedge sys_clk_i);
    chk({30'h0, pready, pslverr}, 32'h0);
    apb(1'b0, {TTSR_IDX_REV, 2'b00}, 32'h0, rd, er); chk(rd, {24'h0, RID});
    // revision expected from the overridden parameter, never a fixed code
    chk(rd, {24'h0, RID});
    apb(1'b1, {TTSR_IDX_PART, 2'b00}, 32'hff, rd, er); chk({31'h0, er}, 32'h1);
    apb(1'b1, {TTSR_IDX_REV, 2'b00}, 32'h00, rd, er); chk({31'h0, er}, 32'h1);
    apb(1'b0, {TTSR_IDX_PART, 2'b00}, 32'h0, rd, er); chk(rd, {24'h0, PID});
    apb(1'b0, 12'h000, 32'h0, rd, er); chk({31'h0, er}, 32'h1);
    apb(1'b1, slot_addr(0) + 12'h1, 32'hc0, rd, er); chk({31'h0, er}, 32'h1);
  endtask

  // selects cycle through all four codes, reserved and low bits written as ones
  task automatic t_regs();
    apb(1'b0, slot_addr(0), 32'h0, rd, er); chk(rd, 32'h80);
    apb(1'b0, slot_addr(31), 32'h0, rd, er); chk(rd, 32'h80);
    for (int k = 0; k < 32; k++)
      apb(1'b1, slot_addr(k), {24'hfff, 2'(k), 6'h3f}, rd, er);
    for (int k = 0; k < 32; k++)
    begin
      apb(1'b0, slot_addr(k), 32'h0, rd, er); chk(rd, {24'h0, 2'(k), 6'h00});
      chk({31'h0, er}, 32'h0);
    end
  endtask

  task automatic step(input logic is_frame);
    @(posedge sys_clk_i);
    if (is_frame) fs <= 1'b1;
    else tick <= 1'b1;
    @(posedge sys_clk_i);
    fs <= 1'b0; tick <= 1'b0;
    #1 chk({31'h0, slot_start}, 32'h1);
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic t_route();
    logic [2:0] exp;
    src <= 2'h3;
    for (int k = 0; k < 33; k++)
    begin
      step(k == 0);
      chk({27'h0, cur_slot}, k % 32);
      case (k % 4)
        0: exp = TTSR_HOT_HDLC1;
        1: exp = TTSR_HOT_HDLC2;
        3: exp = TTSR_HOT_HDLC3;
        default: exp = TTSR_HOT_NONE;
      endcase
      chk({29'h0, route}, {29'h0, exp});
      chk({29'h0, follow, src_o}, (k % 4 == 2) ? 32'h7 : 32'h0);
    end
  endtask

  task automatic t_link();
    @(posedge sys_clk_i);
    dlw <= 1'b1;
    @(posedge sys_clk_i);
    dlw <= 1'b0;
    #1 chk({31'h0, dl1}, 32'h1);
    @(posedge sys_clk_i);
    #1 chk({31'h0, dl1}, 32'h0);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_ident();
    t_regs();
    t_route();
    t_link();
    give_verdict();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #500000;
    num_errors++;
    give_verdict();
  end
endmodule // tx_timeslot_hdlc_select_regs_test
`default_nettype wire
